// [rtl/afc_flow.sv]
// UART autoflow control and transmit DMA request logic with an APB register slave.
// Functional notes
// - FIFO mode: select bit picks DMA signalling type.
// - Non-FIFO mode always uses DMA mode 0.
// - Mode 0 requests one transfer at once.
// - Mode 1 requests until transmit FIFO full.
// - Auto-CTS: start byte only while CTS active.
// - CTS drop: finish byte, hold, resume later.
// - Flow control on: CTS changes raise nothing.
// - No auto-CTS: send regardless of CTS.
// - Levels 1/4/8: drop RTS at trigger level.
// - One more byte accepted after RTS drop.
// - Levels 1/4/8: raise RTS when FIFO empties.
// - Level 14: drop RTS at sixteenth character.
// - Level 14: raise RTS when space allows.
// - Full at level 14: first read raises RTS.
// - Trigger level is 1, 4, 8 or 14.
// - Full autoflow needs enable and RTS bit set.
`timescale 1ns/1ps
`include "afc_regs.svh"
module afc_flow #(
  parameter int AW    = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [AW-1:0]    paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  // Transmit serializer handshake
  output logic                  tx_load,
  output logic [7:0]            tx_byte,
  input  wire logic             tx_byte_done,
  // Receive path status
  input  wire afc_pkg::afc_rx_s rx_info,
  // Modem lines and DMA request
  input  wire logic             clear_to_send_input_n,
  output logic                  request_to_send_output_n,
  output logic                  tx_dma_request_ch0_n
);
  import afc_pkg::*;

  localparam int LW = $clog2(DEPTH + 1);

  afc_ctrl_s ctrl_r;
  afc_ctrl_s ctrl_nxt;
  afc_tx_e   st_r;
  afc_tx_e   st_nxt;
  logic      dcts_r;
  logic      dcts_nxt;
  logic      cts_prev_r;
  logic      hold_r;
  logic      hold_nxt;
  logic      cts_n_s;
  logic      fifo_in_ready;
  logic      fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic [LW-1:0] tx_level;
  logic [7:0] ctrl_word;
  logic [8:0] stat_word;

  afc_sync #(
    .RST_VAL (1'b1)
  ) u_cts_sync (
    .clock (clock),
    .nrst  (nrst),
    .din   (clear_to_send_input_n),
    .dout  (cts_n_s)
  );

  // APB decode; every access takes one wait state, TX data writes stall while full.
  wire acc       = psel & penable;
  wire sel_ctrl  = (paddr == AW'(`AFC_ADDR_CTRL));
  wire sel_stat  = (paddr == AW'(`AFC_ADDR_STAT));
  wire sel_txd   = (paddr == AW'(`AFC_ADDR_TXD));
  wire mapped    = sel_ctrl | sel_stat | sel_txd;
  wire txd_wr    = acc & pwrite & sel_txd;
  wire non_fifo  = ~ctrl_r.fifo_en;
  wire tx_empty  = (tx_level == '0);
  wire tx_room   = fifo_in_ready & (ctrl_r.fifo_en | tx_empty);
  wire tx_full   = ~tx_room;
  wire pready_nx = acc & ~pready & (~txd_wr | tx_room);
  wire done      = acc & pready;
  wire wr_ctrl   = done & pwrite & sel_ctrl;
  wire wr_stat   = done & pwrite & sel_stat;
  wire push      = done & pwrite & sel_txd;
  wire rd_take   = pready_nx & ~pwrite;

  // Flow-control enables.
  wire auto_cts  = ctrl_r.afe;
  wire auto_rts  = ctrl_r.afe & ctrl_r.rts_bit;
  wire rts_bit_w = ctrl_r.rts_bit;
  wire cts_act   = ~cts_n_s;
  wire cts_chg   = cts_prev_r ^ cts_n_s;
  wire mode1     = ctrl_r.fifo_en & ctrl_r.dma_mode;
  wire dma_req_n = mode1 ? tx_full : ~tx_empty;

  // A byte may start only from idle; with auto-CTS the line is checked here.
  wire cts_ok    = ~auto_cts | cts_act;
  wire can_start = (st_r == AFC_TX_IDLE) & fifo_out_valid & cts_ok;

  // Trigger level lookup.
  wire is14      = (ctrl_r.trig == `AFC_TRIG14);
  wire [4:0] trig_lvl = (ctrl_r.trig == `AFC_TRIG1) ? `AFC_LVL1 :
                        (ctrl_r.trig == `AFC_TRIG4) ? `AFC_LVL4 : `AFC_LVL8;
  wire rx_full   = (rx_info.level == `AFC_RX_FULL);
  wire rx_last   = (rx_info.level == `AFC_RX_LAST);

  // Drop and raise conditions; drop wins when both could apply.
  wire drop_low  = (rx_info.level >= trig_lvl);
  wire raise_low = (rx_info.level == '0);
  wire drop_14   = rx_full ? ~rx_info.rbr_read
                           : (rx_info.first_bit & rx_last);
  wire raise_14  = (rx_full & rx_info.rbr_read)
                 | (~rx_full & ~rx_info.char_busy)
                 | (rx_info.level < `AFC_RX_LAST);
  wire drop_any  = is14 ? drop_14 : drop_low;
  wire raise_any = is14 ? raise_14 : raise_low;

  afc_fifo #(
    .W (8),
    .D (DEPTH)
  ) u_tx_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (can_start),
    .out_data  (fifo_out_data),
    .level     (tx_level)
  );

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt.fifo_en  = pwdata[`AFC_B_FIFO_EN];
      ctrl_nxt.rts_bit  = pwdata[`AFC_B_RTS];
      ctrl_nxt.dma_mode = pwdata[`AFC_B_DMA];
      ctrl_nxt.afe      = pwdata[`AFC_B_AFE];
      ctrl_nxt.trig     = pwdata[`AFC_F_TRIG];
    end
  end

  always_comb begin
    ctrl_word                 = '0;
    ctrl_word[`AFC_B_FIFO_EN] = ctrl_r.fifo_en;
    ctrl_word[`AFC_B_RTS]     = ctrl_r.rts_bit;
    ctrl_word[`AFC_B_DMA]     = ctrl_r.dma_mode;
    ctrl_word[`AFC_B_AFE]     = ctrl_r.afe;
    ctrl_word[`AFC_F_TRIG]    = ctrl_r.trig;
    stat_word                 = '0;
    stat_word[`AFC_S_DCTS]    = dcts_r;
    stat_word[`AFC_S_CTS]     = cts_act;
    stat_word[`AFC_S_RTS]     = ~request_to_send_output_n;
    stat_word[`AFC_S_TXBUSY]  = (st_r == AFC_TX_SEND);
    stat_word[`AFC_F_TXLVL]   = 5'(tx_level);
  end

  wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_word} :
                       sel_stat ? {23'h000000, stat_word} : 32'h00000000;

  // The change flag is masked while auto-CTS owns the line; a new change beats a clear.
  always_comb begin
    dcts_nxt = dcts_r;
    if (wr_stat && pwdata[`AFC_S_DCTS]) begin
      dcts_nxt = 1'b0;
    end
    if (cts_chg && !auto_cts) begin
      dcts_nxt = 1'b1;
    end
  end

  // Once a byte is handed over it always completes; only the next start is gated.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      AFC_TX_IDLE: begin
        if (can_start) begin
          st_nxt = AFC_TX_SEND;
        end
      end
      AFC_TX_SEND: begin
        if (tx_byte_done) begin
          st_nxt = AFC_TX_IDLE;
        end
      end
      default: st_nxt = AFC_TX_IDLE;
    endcase
  end

  // Receive data is never refused here, so the extra byte after a drop still lands.
  always_comb begin
    hold_nxt = hold_r;
    if (!auto_rts) begin
      hold_nxt = 1'b0;
    end else if (drop_any) begin
      hold_nxt = 1'b1;
    end else if (raise_any) begin
      hold_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_r     <= afc_ctrl_s'(6'h00);
      st_r       <= AFC_TX_IDLE;
      dcts_r     <= 1'b0;
      cts_prev_r <= 1'b1;
      hold_r     <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      st_r       <= st_nxt;
      dcts_r     <= dcts_nxt;
      cts_prev_r <= cts_n_s;
      hold_r     <= hold_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= pready_nx;
      pslverr <= pready_nx & ~mapped;
      if (rd_take) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tx_load                  <= 1'b0;
      tx_byte                  <= 8'h00;
      request_to_send_output_n <= 1'b1;
      tx_dma_request_ch0_n     <= 1'b1;
    end else begin
      tx_load <= can_start;
      if (can_start) begin
        tx_byte <= fifo_out_data;
      end
      request_to_send_output_n <= auto_rts ? hold_nxt : ~ctrl_r.rts_bit;
      tx_dma_request_ch0_n     <= dma_req_n;
    end
  end

  property p_dma_mode1;
    @(posedge clock) disable iff (!nrst)
      mode1 |=> (tx_dma_request_ch0_n == $past(tx_full));
  endproperty
  a_dma_mode1: assert property (p_dma_mode1)
    else $error("mode 1 request does not follow FIFO full");

  // The last reset edge loads the idle level, so an attempt may only start out of reset.
  property p_dma_mode0;
    @(posedge clock) disable iff (!nrst)
      (nrst && (non_fifo || !ctrl_r.dma_mode)) |=>
        (tx_dma_request_ch0_n == !$past(tx_empty));
  endproperty
  a_dma_mode0: assert property (p_dma_mode0)
    else $error("mode 0 request does not follow FIFO empty");

  property p_cts_gate;
    @(posedge clock) disable iff (!nrst)
      (st_r == AFC_TX_IDLE && auto_cts && cts_n_s) |=> !tx_load;
  endproperty
  a_cts_gate: assert property (p_cts_gate)
    else $error("byte started while CTS inactive");

  property p_byte_once;
    @(posedge clock) disable iff (!nrst)
      tx_load |-> (st_r == AFC_TX_SEND) ##1 !tx_load;
  endproperty
  a_byte_once: assert property (p_byte_once)
    else $error("second byte started during a byte");

  property p_no_msi;
    @(posedge clock) disable iff (!nrst)
      (auto_cts && !dcts_r) |=> !dcts_r;
  endproperty
  a_no_msi: assert property (p_no_msi)
    else $error("CTS change flagged under flow control");

  property p_free_send;
    @(posedge clock) disable iff (!nrst)
      (st_r == AFC_TX_IDLE && fifo_out_valid && !ctrl_r.afe) |=> tx_load;
  endproperty
  a_free_send: assert property (p_free_send)
    else $error("byte held without auto-CTS");

  property p_rts_trig;
    @(posedge clock) disable iff (!nrst)
      (auto_rts && !is14 && rx_info.level >= trig_lvl) |=> request_to_send_output_n;
  endproperty
  a_rts_trig: assert property (p_rts_trig)
    else $error("RTS not dropped at trigger level");

  property p_rts_empty;
    @(posedge clock) disable iff (!nrst)
      (auto_rts && !is14 && rx_info.level == '0) |=> !request_to_send_output_n;
  endproperty
  a_rts_empty: assert property (p_rts_empty)
    else $error("RTS not raised on empty receive FIFO");

  property p_rts_16th;
    @(posedge clock) disable iff (!nrst)
      (auto_rts && is14 && rx_last && rx_info.first_bit) |=> request_to_send_output_n;
  endproperty
  a_rts_16th: assert property (p_rts_16th)
    else $error("RTS not dropped at sixteenth character");

  property p_rts_full_read;
    @(posedge clock) disable iff (!nrst)
      (auto_rts && is14 && rx_full && rx_info.rbr_read) |=> !request_to_send_output_n;
  endproperty
  a_rts_full_read: assert property (p_rts_full_read)
    else $error("RTS not raised by read of full FIFO");

  property p_rts_14_room;
    @(posedge clock) disable iff (!nrst)
      (auto_rts && is14 && rx_info.level < `AFC_RX_LAST) |=> !request_to_send_output_n;
  endproperty
  a_rts_14_room: assert property (p_rts_14_room)
    else $error("RTS not raised with room in receive FIFO");

  property p_rts_manual;
    @(posedge clock) disable iff (!nrst)
      !ctrl_r.afe |=> (request_to_send_output_n == !$past(rts_bit_w));
  endproperty
  a_rts_manual: assert property (p_rts_manual)
    else $error("RTS does not follow control bit");
endmodule

// [rtl/afc_regs.svh]
// Register offsets, field positions and levels of the flow-control block.
`ifndef AFC_REGS_SVH
`define AFC_REGS_SVH
`define AFC_ADDR_CTRL   12'h000
`define AFC_ADDR_STAT   12'h004
`define AFC_ADDR_TXD    12'h008
`define AFC_CTRL_RST    8'h00
`define AFC_B_FIFO_EN   0
`define AFC_B_RTS       1
`define AFC_B_DMA       3
`define AFC_B_AFE       5
`define AFC_F_TRIG      7:6
`define AFC_S_DCTS      0
`define AFC_S_CTS       1
`define AFC_S_RTS       2
`define AFC_S_TXBUSY    3
`define AFC_F_TXLVL     8:4
`define AFC_TRIG1       2'h0
`define AFC_TRIG4       2'h1
`define AFC_TRIG8       2'h2
`define AFC_TRIG14      2'h3
`define AFC_LVL1        5'h01
`define AFC_LVL4        5'h04
`define AFC_LVL8        5'h08
`define AFC_RX_LAST     5'h0f
`define AFC_RX_FULL     5'h10
`endif

// [rtl/afc_pkg.sv]
// Types shared by the flow-control block.
package afc_pkg;
  typedef struct packed {
    logic [1:0] trig;
    logic       afe;
    logic       dma_mode;
    logic       rts_bit;
    logic       fifo_en;
  } afc_ctrl_s;
  typedef struct packed {
    logic [4:0] level;
    logic       char_busy;
    logic       first_bit;
    logic       rbr_read;
  } afc_rx_s;
  typedef enum logic {AFC_TX_IDLE, AFC_TX_SEND} afc_tx_e;
endpackage

// [rtl/afc_sync.sv]
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module afc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Pin side and synchronised level
  input  wire logic din,
  output logic      dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule

// [rtl/afc_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module afc_fifo #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int AW = $clog2(D),
  parameter int LW = $clog2(D + 1)
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          nrst,
  // Fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // Drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [LW-1:0]      level
);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [LW-1:0] cnt_r;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  assign in_ready  = (cnt_r != LW'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign level     = cnt_r;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(D - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(D - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + LW'(push) - LW'(pop);
    end
  end
endmodule

// [tb/afc_peer.sv]
// Serializer and remote receiver model that ends each byte and drives clear-to-send.
`timescale 1ns/1ps
module afc_peer (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Serializer side
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_byte,
  output logic            tx_byte_done,
  // Bench control, pin and tallies
  input  wire logic       stall,
  input  wire logic       stop,
  output logic            cts_n,
  output int              nbytes,
  output logic [7:0]      last_byte
);
  int cnt;
  // A byte takes eight cycles; a stall stretches it so the bench can fill the queue.
  always @(posedge clock) begin
    if (!nrst) begin
      cnt <= 0;
      nbytes <= 0;
      last_byte <= 8'h00;
      cts_n <= 1'b1;
      tx_byte_done <= 1'b0;
    end else begin
      // The bench raises stop early in a byte, far ahead of the last stop bit.
      cts_n <= stop;
      tx_byte_done <= !tx_load && cnt == 1 && !stall;
      if (tx_load) begin
        cnt <= 8;
        nbytes <= nbytes + 1;
        last_byte <= tx_byte;
      end else if (cnt > 0 && !stall) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// [tb/afc_flow_bench.sv]
// Self-checking bench for the autoflow and transmit DMA block.
`timescale 1ns/1ps
`include "afc_regs.svh"
module afc_flow_bench;
  import afc_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er;
  logic        tx_load, tx_byte_done, cts_n, rts_n, dma_n;
  logic        stall = 1'b0;
  logic        stop = 1'b0;
  logic [7:0]  tx_byte, last_b;
  afc_rx_s     rx = '0;
  int          nb, n0, bad_count, compares;
  always #5 clock = ~clock;
  afc_flow DUT (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tx_load(tx_load), .tx_byte(tx_byte),
    .tx_byte_done(tx_byte_done), .rx_info(rx), .clear_to_send_input_n(cts_n),
    .request_to_send_output_n(rts_n), .tx_dma_request_ch0_n(dma_n));
  afc_peer PEER (.clock(clock), .nrst(nrst), .tx_load(tx_load), .tx_byte(tx_byte),
    .tx_byte_done(tx_byte_done), .stall(stall), .stop(stop), .cts_n(cts_n),
    .nbytes(nb), .last_byte(last_b));
  task automatic stop_test();
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // A full-queue write waits for a free slot, so the bound is generous.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 500);
    if (pready !== 1'b1) begin
      bad_count++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic rl(input logic [4:0] l, input logic b, input logic e);
    @(posedge clock);
    rx.level <= l;
    rx.char_busy <= b;
    wt(3);
    chk("rts_n", e, rts_n);
  endtask
  // One pulse of first_bit (f=1) or of rbr_read (f=0), with the level after it.
  task automatic pz(input logic f, input logic [4:0] l);
    @(posedge clock);
    rx.first_bit <= f;
    rx.rbr_read <= !f;
    @(posedge clock);
    rx.first_bit <= 1'b0;
    rx.rbr_read <= 1'b0;
    rx.level <= l;
  endtask
  task automatic t_reset();
    chk("rts_n", 1'b1, rts_n);
    wt(2);
    chk("dma_n", 1'b0, dma_n);
    rdr(`AFC_ADDR_CTRL);
    chk("ctrl", 32'h0, rd);
    rdr(12'h00c);
    chk("pslverr", 1'b1, er);
    chk("rdata", 32'h0, rd);
    wr(`AFC_ADDR_CTRL, 32'hff);
    rdr(`AFC_ADDR_CTRL);
    chk("ctrl", 32'heb, rd);
  endtask
  task automatic t_plain();
    wr(`AFC_ADDR_CTRL, 32'h02);
    rl(5'h10, 1'b0, 1'b0);
    stop <= 1'b1;
    wt(8);
    rdr(`AFC_ADDR_STAT);
    chk("cts_flag", 1'b1, rd[0]);
    n0 = nb;
    wr(`AFC_ADDR_TXD, 32'h5a);
    wt(20);
    chk("bytes", n0 + 1, nb);
    chk("byte", 8'h5a, last_b);
    stop <= 1'b0;
    rl(5'h00, 1'b0, 1'b0);
  endtask
  task automatic t_cts();
    wr(`AFC_ADDR_CTRL, 32'h21);
    wr(`AFC_ADDR_STAT, 32'h1);
    stop <= 1'b1;
    wt(8);
    n0 = nb;
    wr(`AFC_ADDR_TXD, 32'ha1);
    wt(30);
    chk("bytes", n0, nb);
    rdr(`AFC_ADDR_STAT);
    chk("cts_flag", 1'b0, rd[0]);
    chk("rts_n", 1'b1, rts_n);
    stop <= 1'b0;
    wt(20);
    chk("bytes", n0 + 1, nb);
    stall <= 1'b1;
    wr(`AFC_ADDR_TXD, 32'ha2);
    wr(`AFC_ADDR_TXD, 32'ha3);
    stop <= 1'b1;
    wt(8);
    stall <= 1'b0;
    wt(30);
    chk("bytes", n0 + 2, nb);
    stop <= 1'b0;
    wt(30);
    chk("bytes", n0 + 3, nb);
    chk("byte", 8'ha3, last_b);
  endtask
  task automatic t_dma();
    wr(`AFC_ADDR_CTRL, 32'h08);
    n0 = nb;
    stall <= 1'b1;
    wr(`AFC_ADDR_TXD, 32'hb0);
    wt(3);
    chk("dma_n", 1'b0, dma_n);
    wr(`AFC_ADDR_TXD, 32'hb1);
    wt(3);
    chk("dma_n", 1'b1, dma_n);
    wr(`AFC_ADDR_CTRL, 32'h01);
    wt(3);
    chk("dma_n", 1'b1, dma_n);
    wr(`AFC_ADDR_CTRL, 32'h09);
    wt(3);
    chk("dma_n", 1'b0, dma_n);
    for (int i = 0; i < 14; i++) begin
      wr(`AFC_ADDR_TXD, i);
    end
    wt(3);
    chk("dma_n", 1'b0, dma_n);
    wr(`AFC_ADDR_TXD, 32'h0e);
    wt(3);
    chk("dma_n", 1'b1, dma_n);
    rdr(`AFC_ADDR_STAT);
    chk("tx_level", `AFC_RX_FULL, rd[8:4]);
    stall <= 1'b0;
    wt(250);
    chk("bytes", n0 + 17, nb);
    chk("byte", 8'h0e, last_b);
    chk("dma_n", 1'b0, dma_n);
  endtask
  task automatic t_rts();
    logic [4:0] lv[3];
    lv = '{`AFC_LVL1, `AFC_LVL4, `AFC_LVL8};
    for (int t = 0; t < 3; t++) begin
      wr(`AFC_ADDR_CTRL, {24'h0, t[1:0], 6'h23});
      rl(5'h00, 1'b0, 1'b0);
      rl(lv[t] - 5'h01, 1'b0, 1'b0);
      rl(lv[t], 1'b1, 1'b1);
      rl(lv[t] + 5'h01, 1'b0, 1'b1);
      rl(5'h01, 1'b0, 1'b1);
      rl(5'h00, 1'b0, 1'b0);
    end
    wr(`AFC_ADDR_CTRL, 32'he3);
    rl(5'h0e, 1'b0, 1'b0);
    rl(5'h0f, 1'b1, 1'b0);
    pz(1'b1, 5'h0f);
    rl(5'h0f, 1'b1, 1'b1);
    rl(5'h0f, 1'b0, 1'b0);
    pz(1'b1, 5'h0f);
    rl(5'h10, 1'b0, 1'b1);
    pz(1'b0, 5'h0f);
    rl(5'h0f, 1'b1, 1'b0);
    rl(5'h00, 1'b0, 1'b0);
  endtask
  initial begin
    wt(16);
    nrst <= 1'b1;
    t_reset();
    t_plain();
    t_cts();
    t_dma();
    t_rts();
    stop_test();
  end
endmodule
